// ==== rtl/ext_bus_read_wait_control.v ====
// external bus read strobe, direction line and wait-state control
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.vh"
module ext_bus_read_wait_control (
   input wire clock,
   input wire rst_n,
   input wire bus_owned,
   input wire access_req,
   input wire access_read,
   input wire access_space,
   input wire [`ADDR_W-1:0] access_addr,
   input wire [`WAIT_W-1:0] wait_config_reg,
   input wire transfer_ack_n,
   input wire [`DATA_W-1:0] ext_data_in,
   output reg read_strobe_n,
   output reg read_strobe_oe,
   output reg read_write_dir,
   output reg dir_oe,
   output reg [`ADDR_W-1:0] ext_addr,
   output reg space_select,
   output reg ext_data_in_mode,
   output reg [1:0] phase,
   output reg access_done,
   output reg [`DATA_W-1:0] read_data
);

   // ----------------------------------------
   // internal state
   // ----------------------------------------
   // acknowledge synchroniser chain and its filtered level
   reg ack_s1;
   reg ack_s2;
   reg ack_s3;
   reg ack;
   // access bookkeeping, valid from take to phase_three
   reg active;
   reg is_read;
   reg ack_seen;
   // programmed wait periods still owed
   reg [`WAIT_W-1:0] wcount;
   // read word held between phase_two and phase_three
   reg [`DATA_W-1:0] data_latch;
   reg [1:0] next_phase;
   wire take;
   wire cnt_done;
   wire holding;
   wire finish;
   wire closing;

   // ----------------------------------------
   // cycle events
   // ----------------------------------------
   // a request without the bus is dropped, not queued
   assign take = (phase == `PH_ZERO) && access_req && bus_owned;
   assign cnt_done = (wcount == `WAIT_NONE);
   // either source may hold phase_two: the larger demand wins
   assign holding = (phase == `PH_TWO) && active &&
      !(cnt_done && ack_seen);
   assign finish = (phase == `PH_TWO) && active && cnt_done && ack_seen;
   assign closing = (phase == `PH_THREE) && active;

   // ----------------------------------------
   // pin synchroniser for the acknowledge
   // ----------------------------------------
   // only the agreeing pair is trusted, so a glitch on the pin
   // shorter than a clock never reaches the wait logic
   always @(posedge clock) begin
      if (!rst_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
         ack <= 1'b0;
      end else begin
         ack_s1 <= transfer_ack_n;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         if (ack_s2 == ack_s3) begin
            ack <= ack_s3;
         end
      end
   end

   // ----------------------------------------
   // phase sequencing
   // ----------------------------------------
   // one phase per clock: a wait period is one whole clock in
   // phase_two, which keeps the stretch count easy to reason about
   always @* begin
      next_phase = phase;
      case (phase)
         `PH_ZERO: begin
            next_phase = `PH_ONE;
         end
         `PH_ONE: begin
            next_phase = `PH_TWO;
         end
         `PH_TWO: begin
            if (holding) begin
               next_phase = `PH_TWO;
            end else begin
               next_phase = `PH_THREE;
            end
         end
         default: begin
            next_phase = `PH_ZERO;
         end
      endcase
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         phase <= `RST_PHASE;
      end else begin
         phase <= next_phase;
      end
   end

   // ----------------------------------------
   // access tracking
   // ----------------------------------------
   // re-decided at every phase_zero, so an idle cycle clears it
   always @(posedge clock) begin
      if (!rst_n) begin
         active <= 1'b0;
         is_read <= 1'b0;
      end else if (phase == `PH_ZERO) begin
         active <= take;
         if (take) begin
            is_read <= access_read;
         end
      end
   end

   // ----------------------------------------
   // programmed wait counter
   // ----------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         wcount <= `WAIT_NONE;
      end else if (take) begin
         wcount <= wait_config_reg;
      end else if (holding && !cnt_done) begin
         wcount <= wcount - 1'b1;
      end
   end

   // ----------------------------------------
   // acknowledge tracking
   // ----------------------------------------
   // a low seen in one wait period releases the next one, which
   // gives the two-phase tail after the acknowledge
   always @(posedge clock) begin
      if (!rst_n) begin
         ack_seen <= 1'b0;
      end else if (take) begin
         ack_seen <= ~ack;
      end else if ((phase == `PH_TWO) && active && !ack) begin
         ack_seen <= 1'b1;
      end
   end

   // ----------------------------------------
   // address and space outputs
   // ----------------------------------------
   // held through idle cycles so the pins do not toggle for nothing
   always @(posedge clock) begin
      if (!rst_n) begin
         ext_addr <= {`ADDR_W{1'b0}};
         space_select <= `RST_SPACE;
      end else if (take) begin
         ext_addr <= access_addr;
         space_select <= access_space;
      end
   end

   // ----------------------------------------
   // direction line
   // ----------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         read_write_dir <= `RST_DIR;
      end else if (phase == `PH_ZERO) begin
         if (take) begin
            read_write_dir <= access_read;
         end else begin
            read_write_dir <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // read strobe
   // ----------------------------------------
   // stays low through every wait period of the read
   always @(posedge clock) begin
      if (!rst_n) begin
         read_strobe_n <= `RST_STROBE_N;
      end else if (take && access_read) begin
         read_strobe_n <= 1'b0;
      end else if (closing) begin
         read_strobe_n <= 1'b1;
      end
   end

   // ----------------------------------------
   // pin drive enables
   // ----------------------------------------
   // one clock late after losing the bus: the owner must not
   // hand the bus on within that clock
   always @(posedge clock) begin
      if (!rst_n) begin
         read_strobe_oe <= 1'b0;
         dir_oe <= 1'b0;
      end else begin
         read_strobe_oe <= bus_owned;
         dir_oe <= bus_owned;
      end
   end

   // ----------------------------------------
   // data pin direction
   // ----------------------------------------
   // pins go back to input after every access, so a parked bus
   // is never driven
   always @(posedge clock) begin
      if (!rst_n) begin
         ext_data_in_mode <= `RST_DATA_MODE;
      end else if (take) begin
         ext_data_in_mode <= access_read;
      end else if (closing) begin
         ext_data_in_mode <= `RST_DATA_MODE;
      end
   end

   // ----------------------------------------
   // read data capture
   // ----------------------------------------
   // captured on leaving phase_two, shown at the strobe release
   genvar gi;
   generate
      for (gi = 0; gi < `DATA_W; gi = gi + 1) begin : g_bit
         always @(posedge clock) begin
            if (!rst_n) begin
               data_latch[gi] <= 1'b0;
               read_data[gi] <= 1'b0;
            end else begin
               if (finish && is_read) begin
                  data_latch[gi] <= ext_data_in[gi];
               end
               if (closing && is_read) begin
                  read_data[gi] <= data_latch[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // completion pulse
   // ----------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         access_done <= 1'b0;
      end else begin
         access_done <= closing;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/ext_bus_defs.vh ====
// constants for the external bus read and wait-state control
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define PH_ZERO 2'h0
`define PH_ONE 2'h1
`define PH_TWO 2'h2
`define PH_THREE 2'h3
`define WAIT_W 4
`define ADDR_W 16
`define DATA_W 16
`define RST_PHASE 2'h0
`define RST_STROBE_N 1'b1
`define RST_DIR 1'b1
`define RST_SPACE 1'b1
`define RST_DATA_MODE 1'b1
`define WAIT_NONE 4'h0
`endif

// ==== sim/ext_bus_read_wait_control_checker.sv ====
// checker for strobe, direction and phase timing
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chk (
   input wire logic clock, rst_n, bus_owned, access_req, access_read,
   input wire logic read_strobe_n, read_strobe_oe, read_write_dir,
   input wire logic access_done, access_space, space_select,
   input wire logic ext_data_in_mode, dir_oe,
   input wire logic [1:0] phase
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire tk = phase == 2'h0 && access_req && bus_owned;
   property p_wr; phase == 2'h3 |=> phase == 2'h0; endproperty
   a_wr: assert property (p_wr) else $error("phase wrap");
   property p_dn; $rose(read_strobe_n) |-> access_done; endproperty
   a_dn: assert property (p_dn) else $error("done");
   property p_rd; tk && access_read |=> !read_strobe_n; endproperty
   a_rd: assert property (p_rd) else $error("strobe");
   property p_wt; tk && !access_read |=> read_strobe_n; endproperty
   a_wt: assert property (p_wt) else $error("write strobe");
   property p_dr; tk |=> read_write_dir == $past(access_read); endproperty
   a_dr: assert property (p_dr) else $error("dir");
   property p_id; phase == 2'h0 && !access_req |=> read_write_dir; endproperty
   a_id: assert property (p_id) else $error("idle dir");
   property p_oe; !bus_owned |=> !read_strobe_oe; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_sp; tk |=> space_select == $past(access_space); endproperty
   a_sp: assert property (p_sp) else $error("space");
   property p_dm; tk && !access_read |=> !ext_data_in_mode; endproperty
   a_dm: assert property (p_dm) else $error("data mode");
   property p_do; !bus_owned |=> !dir_oe; endproperty
   a_do: assert property (p_do) else $error("dir oe");
   property p_ws; !read_strobe_n && phase == 2'h2 |-> ##[0:40] phase == 2'h3;
   endproperty
   a_ws: assert property (p_ws) else $error("wait");
endmodule
bind ext_bus_read_wait_control ext_bus_chk i_chk (.*);
`default_nettype wire

// ==== sim/ext_mem_model.sv ====
// external memory: data from address, ack held high to stall
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input wire logic clock, read_strobe_n,
   input wire logic [15:0] ext_addr,
   input wire logic [3:0] stall,
   output logic transfer_ack_n,
   output logic [15:0] ext_data_in
);
   logic [3:0] cnt = 4'h0;
   logic [15:0] junk = 16'h0;
   // stall loaded while idle, so ack is already high before the cycle
   always @(posedge clock) begin
      junk <= junk + 16'h1357;
      cnt <= read_strobe_n ? stall : cnt - {3'h0, cnt != 4'h0};
   end
   assign transfer_ack_n = cnt != 4'h0;
   assign ext_data_in = read_strobe_n ? junk : ext_addr ^ 16'h5a5a;
endmodule
`default_nettype wire

// ==== sim/ext_bus_read_wait_control_tb.sv ====
// self-checking bench for the read and wait control
`timescale 1ns/1ps
`default_nettype none
module ext_bus_read_wait_control_tb;
   logic clock = 0, rst_n = 0, own = 1, req = 0, rd = 0;
   logic ack_n, rs_n, oe, dir, done;
   logic [1:0] ph;
   logic [3:0] wc = 4'h0, st = 4'h0;
   logic [15:0] addr = 16'h0, din, rdat, xa;
   int num_errors = 0, check_count = 0, cyc = 0, n = 0, n0 = 0;
   always #5 clock = ~clock;
   ext_mem_model i_mem (.clock(clock), .read_strobe_n(rs_n), .ext_addr(xa),
      .stall(st), .transfer_ack_n(ack_n), .ext_data_in(din));
   ext_bus_read_wait_control i_dut (.clock(clock), .rst_n(rst_n),
      .bus_owned(own), .access_req(req), .access_read(rd),
      .access_space(addr[0]), .access_addr(addr), .wait_config_reg(wc),
      .transfer_ack_n(ack_n), .ext_data_in(din), .read_strobe_n(rs_n),
      .read_strobe_oe(oe), .read_write_dir(dir), .dir_oe(), .ext_addr(xa),
      .space_select(), .ext_data_in_mode(), .phase(ph),
      .access_done(done), .read_data(rdat));
   task chk(input string nm, input logic [15:0] e, s);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ack needs a few clocks through its synchroniser before the take
   task acc(input logic r, input logic [15:0] a, input logic [3:0] w, s);
      wc = w;
      st = s;
      repeat (8) @(posedge clock);
      #1;
      while (ph !== 2'h0) begin
         @(posedge clock);
         #1;
      end
      req = 1;
      rd = r;
      addr = a;
      n = 0;
      @(posedge clock);
      #1;
      req = 0;
      while (done !== 1'b1 && n < 60) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask
   task t_rd;
      acc(1, 16'h1234, 4'h0, 4'h0);
      n0 = n;
      chk("data", 16'h486e, rdat);
      chk("done", 16'h1, {15'h0, n0 < 60});
      acc(1, 16'hbeef, 4'h3, 4'h0);
      chk("cfg", 16'h1, {15'h0, n >= n0 + 3});
      acc(1, 16'h0f0f, 4'h0, 4'h8);
      chk("ack", 16'h1, {15'h0, n > n0 + 4});
      chk("data", 16'h5555, rdat);
      $display("read tests over");
   endtask
   task t_wr;
      acc(0, 16'h00aa, 4'h0, 4'h0);
      repeat (4) @(posedge clock);
      #1;
      chk("dir", 16'h1, {15'h0, dir});
      own = 0;
      acc(1, 16'h0001, 4'h0, 4'h0);
      chk("oe", 16'h0, {15'h0, oe});
      chk("refused", 16'd60, n[15:0]);
      own = 1;
      $display("write and release tests over");
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         print_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      #1 rst_n = 1;
      t_rd;
      t_wr;
      print_verdict;
   end
endmodule
`default_nettype wire
